// *** core/scc_core.sv ***
// Operation
// - received words land in a receive buffer; sent words wait in a transmit buffer
// - data window read returns receive buffer; write loads transmit buffer
// - with send-next set, checksum follows last word; send-next clears itself as that last word completes
// - partner checksum compared with receive checksum; mismatch sets flag, error irq
// - checksum reacts to serial clock rising edges once enabled, regardless of peripheral enable
// - in slave mode checksum keeps updating while slave select is high
// - disabled peripheral, checksum enable cleared then set, resets checksum values
// - three interrupt sources backed by seven pending indications
// - mismatch, mode fault spi only; underrun, frame error i2s only; overrun both
// - two separately enabled dma requests for tx space and rx data
// - link busy shows serial layer activity or a non-empty transmit buffer
`timescale 1ns/1ns
module scc_core
   import scc_pkg::*;
(
   input wire logic sys_clk, // core clock
   input wire logic srst, // sync reset, active high
   input wire logic clk_en, // freezes all state when low
   input wire logic peripheral_enable, // link enable
   input wire logic checksum_enable, // checksum unit enable
   input wire logic word16, // 1: 16-bit words, 0: 8-bit
   input wire logic i2s_mode, // 1: audio mode
   input wire logic [DATA_W-1:0] crc_poly, // checksum polynomial
   input wire logic set_send_next, // pulse: append checksum
   input wire logic [DATA_W-1:0] dw_wdata, // data window write value
   input wire logic dw_wvalid, // data window write strobe
   output logic dw_wready, // transmit buffer has room
   output logic [DATA_W-1:0] dw_rdata, // data window read value
   input wire logic dw_rd, // data window read strobe
   input wire logic clr_mismatch, // pulse: clear checksum mismatch
   input wire logic clr_overrun, // pulse: clear overrun
   input wire logic mode_fault_in, // mode fault event
   input wire logic underrun_in, // audio underrun event
   input wire logic frame_err_in, // audio frame error event
   input wire logic channel_side_in, // audio channel side
   input wire logic clr_audio_err, // pulse: clear audio errors and mode fault
   input wire logic tx_irq_enable, // tx empty interrupt enable
   input wire logic rx_irq_enable, // rx not empty interrupt enable
   input wire logic error_irq_enable, // error interrupt enable
   input wire logic tx_dma_enable, // tx dma request enable
   input wire logic rx_dma_enable, // rx dma request enable
   input wire logic sck_pin, // slave serial clock
   input wire logic ssn_pin, // slave_select_n pin
   input wire logic mosi_pin, // serial data in
   output logic miso_pin, // serial data out
   output logic miso_oe, // high while driving serial out
   output scc_flags_type flags, // status flags
   output logic [6:0] pending, // seven pending indications
   output logic tx_irq, // tx buffer empty interrupt
   output logic rx_irq, // rx not empty interrupt
   output logic err_irq, // combined error interrupt
   output logic tx_dma_request, // tx dma request
   output logic rx_dma_request, // rx dma request
   output logic [DATA_W-1:0] rx_checksum_register, // receive checksum
   output logic [DATA_W-1:0] tx_checksum_value // transmit checksum
);

   scc_state_type cur_ff;
   scc_state_type nxt_ff;
   logic sck_rise;
   logic sck_fall;
   logic ssn_low;
   logic sdi;
   logic [CNT_W-1:0] wlen;
   logic crc_restart;
   logic push;
   logic last_bit;
   logic [DATA_W-1:0] msb_mask;

   // the core is a slave only: the partner owns the serial clock and select.
   // all pins run through three stages; a clock edge is taken once the new level reaches stage two.
   // every flag that hardware sets and a pulse clears lets the set win when
   // both fall in one cycle, so no event is ever lost to a late clear.

   // ------------------------------------------------------------
   // pin sampling and decode
   // ------------------------------------------------------------
   // edge when stage two holds the new level and stage three still the old one
   assign sck_rise = cur_ff.sync.sck[1] & ~cur_ff.sync.sck[2];
   assign sck_fall = ~cur_ff.sync.sck[1] & cur_ff.sync.sck[2];
   assign ssn_low = ~cur_ff.sync.ssn[2];
   assign sdi = cur_ff.sync.mosi[2];
   assign wlen = word16 ? BITS_16 : BITS_8;
   assign last_bit = (cur_ff.bitn == wlen - 5'h01);
   assign msb_mask = word16 ? 16'h8000 : 16'h0080;
   assign crc_restart = checksum_enable & ~cur_ff.crc_en_d & ~peripheral_enable;
   assign push = dw_wvalid & (cur_ff.tx_cnt != BUF_DEPTH);

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb
   begin
      logic crc_fb;
      logic [DATA_W-1:0] load;
      logic pop;
      logic rx_load;
      crc_fb = 1'b0;
      load = '0;
      pop = 1'b0;
      rx_load = 1'b0;
      nxt_ff = cur_ff;
      // error clears first, so that a set later in this cycle wins
      if (clr_mismatch)
         nxt_ff.flags.checksum_mismatch = 1'b0;
      if (clr_overrun)
         nxt_ff.flags.overrun_error = 1'b0;
      if (clr_audio_err)
      begin
         nxt_ff.flags.underrun_error = 1'b0;
         nxt_ff.flags.frame_format_error = 1'b0;
         nxt_ff.flags.mode_fault = 1'b0;
      end
      nxt_ff.sync.sck = {cur_ff.sync.sck[1:0], sck_pin};
      nxt_ff.sync.ssn = {cur_ff.sync.ssn[1:0], ssn_pin};
      nxt_ff.sync.mosi = {cur_ff.sync.mosi[1:0], mosi_pin};
      nxt_ff.crc_en_d = checksum_enable;
      nxt_ff.flags.channel_side = channel_side_in;
      if (set_send_next)
         nxt_ff.send_next = 1'b1;
      if (crc_restart)
      begin
         nxt_ff.crc_tx = CRC_INIT;
         nxt_ff.crc_rx = CRC_INIT;
      end
      // checksum on every rising edge outside the checksum phase, select ignored
      if (checksum_enable && sck_rise && cur_ff.phase != SCC_CRC)
      begin
         crc_fb = sdi ^ |(cur_ff.crc_rx & msb_mask);
         nxt_ff.crc_rx = (cur_ff.crc_rx << 1) ^ (crc_fb ? crc_poly : '0);
         crc_fb = cur_ff.miso ^ |(cur_ff.crc_tx & msb_mask);
         nxt_ff.crc_tx = (cur_ff.crc_tx << 1) ^ (crc_fb ? crc_poly : '0);
      end
      // receive shift and word completion
      if (peripheral_enable && ssn_low && sck_rise)
      begin
         nxt_ff.shift_in = {cur_ff.shift_in[DATA_W-2:0], sdi};
         nxt_ff.bitn = cur_ff.bitn + 5'h01;
         if (cur_ff.phase == SCC_IDLE)
            nxt_ff.phase = SCC_DATA;
         if (last_bit)
         begin
            nxt_ff.bitn = BIT_ZERO;
            if (cur_ff.phase == SCC_CRC)
            begin
               if ({cur_ff.shift_in[DATA_W-2:0], sdi} != (cur_ff.crc_rx & (word16 ? 16'hffff : 16'h00ff)))
                  nxt_ff.flags.checksum_mismatch = 1'b1;
               nxt_ff.phase = SCC_IDLE;
            end
            else
            begin
               // receive buffer fill, overrun if unread
               if (cur_ff.flags.rx_buffer_not_empty && !dw_rd)
                  nxt_ff.flags.overrun_error = 1'b1;
               else
               begin
                  // short words sit in the low byte, upper byte reads zero
                  if (word16)
                     nxt_ff.rx_buf = {cur_ff.shift_in[DATA_W-2:0], sdi};
                  else
                     nxt_ff.rx_buf = {8'h00, cur_ff.shift_in[6:0], sdi};
                  nxt_ff.flags.rx_buffer_not_empty = 1'b1;
                  rx_load = 1'b1;
               end
               if (cur_ff.send_next && cur_ff.tx_cnt == BUF_ZERO)
               begin
                  nxt_ff.phase = SCC_CRC;
                  nxt_ff.send_next = 1'b0;
               end
               else if (cur_ff.tx_cnt == BUF_ZERO)
                  nxt_ff.phase = SCC_IDLE;
            end
         end
      end
      // transmit shift on falling edge, load at word start
      if (peripheral_enable && ssn_low && sck_fall)
      begin
         if (cur_ff.bitn == BIT_ZERO)
         begin
            if (cur_ff.phase == SCC_CRC)
               load = cur_ff.crc_tx;
            else if (cur_ff.tx_cnt != BUF_ZERO)
            begin
               load = cur_ff.txq[0];
               pop = 1'b1;
            end
            else if (i2s_mode)
               nxt_ff.flags.underrun_error = 1'b1;
            nxt_ff.shift_out = word16 ? load : {load[7:0], 8'h00};
            nxt_ff.miso = word16 ? load[15] : load[7];
            if (word16)
               nxt_ff.shift_out = {load[14:0], 1'b0};
            else
               nxt_ff.shift_out = {load[6:0], 9'h000};
         end
         else
         begin
            nxt_ff.miso = cur_ff.shift_out[DATA_W-1];
            nxt_ff.shift_out = {cur_ff.shift_out[DATA_W-2:0], 1'b0};
         end
      end
      if (pop)
      begin
         nxt_ff.txq[0] = cur_ff.txq[1];
         nxt_ff.tx_cnt = cur_ff.tx_cnt - 2'h1;
      end
      if (push)
      begin
         nxt_ff.txq[nxt_ff.tx_cnt[0]] = dw_wdata;
         nxt_ff.tx_cnt = nxt_ff.tx_cnt + 2'h1;
      end
      nxt_ff.flags.tx_buffer_empty = (nxt_ff.tx_cnt == BUF_ZERO);
      // data window read drains receive buffer
      // a word landing in the same cycle keeps the flag set
      if (dw_rd && !rx_load)
         nxt_ff.flags.rx_buffer_not_empty = 1'b0;
      nxt_ff.flags.link_busy = (nxt_ff.phase != SCC_IDLE) | ~nxt_ff.flags.tx_buffer_empty;
      // outside error events; clears were applied above, so sets win
      if (mode_fault_in)
         nxt_ff.flags.mode_fault = 1'b1;
      if (frame_err_in)
         nxt_ff.flags.frame_format_error = 1'b1;
      if (underrun_in)
         nxt_ff.flags.underrun_error = 1'b1;
      if (!peripheral_enable)
      begin
         nxt_ff.phase = SCC_IDLE;
         nxt_ff.bitn = BIT_ZERO;
      end
   end

   // ------------------------------------------------------------
   // state register
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         cur_ff <= '0;
         // clock idles high: a low reset value would fake a rising edge
         cur_ff.sync.sck <= 3'h7;
         cur_ff.sync.ssn <= 3'h7;
         cur_ff.crc_tx <= CRC_INIT;
         cur_ff.crc_rx <= CRC_INIT;
         cur_ff.phase <= SCC_IDLE;
         cur_ff.flags.tx_buffer_empty <= 1'b1;
      end
      else if (clk_en)
         cur_ff <= nxt_ff;
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   // status flags, mode-filtered
   always_comb
   begin
      flags = cur_ff.flags;
      flags.checksum_mismatch = cur_ff.flags.checksum_mismatch & ~i2s_mode;
      flags.mode_fault = cur_ff.flags.mode_fault & ~i2s_mode;
      flags.underrun_error = cur_ff.flags.underrun_error & i2s_mode;
      flags.frame_format_error = cur_ff.flags.frame_format_error & i2s_mode;
   end
   assign pending = {flags.tx_buffer_empty, flags.rx_buffer_not_empty, flags.checksum_mismatch,
                     flags.mode_fault, flags.overrun_error, flags.underrun_error, flags.frame_format_error};
   assign tx_irq = tx_irq_enable & flags.tx_buffer_empty;
   assign rx_irq = rx_irq_enable & flags.rx_buffer_not_empty;
   assign err_irq = error_irq_enable & (flags.checksum_mismatch | flags.mode_fault | flags.overrun_error
                                        | flags.underrun_error | flags.frame_format_error);
   // dma requests
   // tx request follows buffer room, rx request follows held data
   assign tx_dma_request = tx_dma_enable & dw_wready;
   assign rx_dma_request = rx_dma_enable & cur_ff.flags.rx_buffer_not_empty;
   assign dw_wready = (cur_ff.tx_cnt != BUF_DEPTH);
   assign dw_rdata = cur_ff.rx_buf;
   assign miso_pin = cur_ff.miso;
   // serial out is driven only while enabled and selected
   assign miso_oe = peripheral_enable & ssn_low;
   // checksum values are visible for reading at any time
   assign rx_checksum_register = cur_ff.crc_rx;
   assign tx_checksum_value = cur_ff.crc_tx;
endmodule

// *** core/scc_pkg.sv ***
package scc_pkg;
   // ------------------------------------------------------------
   // widths and constants
   // ------------------------------------------------------------
   localparam int DATA_W = 16;
   localparam int CNT_W = 5;
   localparam logic [DATA_W-1:0] CRC_INIT = 16'h0000;
   localparam logic [DATA_W-1:0] CRC_POLY_RST = 16'h0007;
   localparam logic [CNT_W-1:0] BIT_ZERO = 5'h00;
   localparam logic [CNT_W-1:0] BITS_8 = 5'h08;
   localparam logic [CNT_W-1:0] BITS_16 = 5'h10;
   localparam logic [1:0] BUF_ZERO = 2'h0;
   localparam logic [1:0] BUF_DEPTH = 2'h2;
   localparam int BUF_MSB = 1;

   // pin synchroniser taps (three stages)
   typedef struct packed {
      logic [2:0] sck;
      logic [2:0] ssn;
      logic [2:0] mosi;
   } scc_sync_type;

   // status flag group
   typedef struct packed {
      logic tx_buffer_empty;
      logic rx_buffer_not_empty;
      logic link_busy;
      logic checksum_mismatch;
      logic mode_fault;
      logic overrun_error;
      logic frame_format_error;
      logic underrun_error;
      logic channel_side;
   } scc_flags_type;

   typedef enum logic [1:0] {
      SCC_IDLE,
      SCC_DATA,
      SCC_CRC
   } scc_phase_type;

   // whole state of the core
   typedef struct packed {
      scc_sync_type sync;
      logic [1:0][DATA_W-1:0] txq;
      logic [1:0] tx_cnt;
      logic [DATA_W-1:0] rx_buf;
      logic [DATA_W-1:0] shift_out;
      logic [DATA_W-1:0] shift_in;
      logic [CNT_W-1:0] bitn;
      logic [DATA_W-1:0] crc_tx;
      logic [DATA_W-1:0] crc_rx;
      logic crc_en_d;
      logic send_next;
      logic miso;
      scc_phase_type phase;
      scc_flags_type flags;
   } scc_state_type;
endpackage

// *** tb/scc_core_sva.sv ***
`timescale 1ns/1ns
module scc_core_sva
   import scc_pkg::*;
(
   input wire logic sys_clk, // clock
   input wire logic srst, // reset
   input wire logic clk_en, // enable
   input wire logic i2s_mode, // audio mode
   input wire logic dw_wvalid, // write strobe
   input wire logic dw_wready, // tx room
   input wire logic tx_irq_enable, // tx irq on
   input wire logic rx_irq_enable, // rx irq on
   input wire logic error_irq_enable, // err irq on
   input wire logic tx_dma_enable, // tx dma on
   input wire logic rx_dma_enable, // rx dma on
   input wire scc_flags_type flags, // status
   input wire logic [6:0] pending, // pending bits
   input wire logic tx_irq, // tx irq
   input wire logic rx_irq, // rx irq
   input wire logic err_irq, // err irq
   input wire logic tx_dma_request, // tx dma
   input wire logic rx_dma_request, // rx dma
   input wire logic [DATA_W-1:0] rx_checksum_register // rx checksum
);
   // ----
   // port relations
   // ----
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (srst);
   chk_reset_state: assert property (disable iff (1'b0)
      srst |=> flags == 9'h100 && rx_checksum_register == 16'h0000) else $error("bad reset state");
   chk_write_fill: assert property (
      dw_wvalid && dw_wready && clk_en |=> !flags.tx_buffer_empty) else $error("write lost");
   chk_err_line: assert property (
      err_irq == (error_irq_enable && |pending[4:0])) else $error("bad error irq");
   chk_pending_map: assert property (
      pending == {flags[8:7], flags[5:3], flags[1], flags[2]}) else $error("bad pending");
   chk_irq_lines: assert property (
      tx_irq == (tx_irq_enable && pending[6]) && rx_irq == (rx_irq_enable && pending[5])) else $error("bad irq");
   chk_dma_lines: assert property (
      rx_dma_request == (rx_dma_enable && pending[5]) && (!tx_dma_request || tx_dma_enable && dw_wready))
      else $error("bad dma request");
   chk_spi_only: assert property (
      i2s_mode && $past(i2s_mode) |-> !flags.checksum_mismatch && !flags.mode_fault) else $error("spi flag");
   chk_audio_only: assert property (
      !i2s_mode && !$past(i2s_mode) |-> !flags.underrun_error && !flags.frame_format_error) else $error("i2s flag");
   chk_busy_fill: assert property (
      !flags.tx_buffer_empty && !$past(flags.tx_buffer_empty) |-> flags.link_busy) else $error("busy low");
   cover property (dw_wvalid && !dw_wready);
   cover property ($rose(flags.checksum_mismatch));
   cover property ($rose(flags.overrun_error));
endmodule

bind scc_core scc_core_sva i_scc_core_sva (.*);

// *** tb/scc_spi_master.sv ***
`timescale 1ns/1ns
module scc_spi_master
(
   output logic sck, // serial clock, idle high
   output logic ssn, // select, active low
   output logic mosi, // data to slave
   input wire logic miso // data from slave
);
   // idle: clock stands high, deselected
   initial
   begin
      sck = 1'b1;
      ssn = 1'b1;
      mosi = 1'b0;
   end
   // ----
   // frame of words, msb first, 32 ns bits
   // ----
   // select low through data and checksum while sel is set, else held high
   task automatic frame(input logic [15:0] tx[$], input int nb, input logic sel, output logic [15:0] rx[$]);
      logic [15:0] w;
      rx = {};
      w = 16'h0000;
      #33 ssn = !sel;
      #32;
      foreach (tx[i])
      begin
         for (int b = nb - 1; b >= 0; b--)
         begin
            sck = 1'b0;
            mosi = tx[i][b];
            #16 sck = 1'b1;
            #15 w = {w[14:0], miso};
            #1;
         end
         rx.push_back(w);
      end
      #32 ssn = 1'b1;
      // released line shows the inverse bit
      mosi = !mosi;
   endtask
endmodule

// *** tb/scc_core_tb.sv ***
`timescale 1ns/1ns
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin fail_count++; \
   $display("wrong value at %0t: got %h expected %h", $time, a, e); end end
module scc_core_tb
   import scc_pkg::*;
;
   logic sys_clk = 1'b0;
   logic srst, clk_en, peripheral_enable, checksum_enable, word16, i2s_mode, set_send_next, dw_wvalid, dw_rd;
   logic clr_mismatch, clr_overrun, mode_fault_in, underrun_in, frame_err_in, channel_side_in, clr_audio_err;
   logic tx_irq_enable, rx_irq_enable, error_irq_enable, tx_dma_enable, rx_dma_enable, sck_pin, ssn_pin, mosi_pin;
   logic dw_wready, miso_pin, miso_oe, tx_irq, rx_irq, err_irq, tx_dma_request, rx_dma_request, auto_rd;
   logic [DATA_W-1:0] crc_poly, dw_wdata, dw_rdata, rx_checksum_register, tx_checksum_value, d0;
   logic [6:0] pending;
   scc_flags_type flags;
   logic [15:0] tq[$], mq[$], rxq[$];
   int fail_count = 0;
   int samples_checked = 0;
   int unsigned seed = 69;

   always #2 sys_clk = !sys_clk;

   scc_core i_scc_core (.*);
   scc_spi_master i_scc_spi_master (.sck(sck_pin), .ssn(ssn_pin), .mosi(mosi_pin), .miso(miso_pin));

   // ----
   // helpers
   // ----
   function automatic logic [15:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[15:0];
   endfunction

   // msb first checksum of one word from zero
   function automatic logic [15:0] crc_of(input logic [15:0] d);
      logic [15:0] r;
      r = 16'h0000;
      for (int b = 15; b >= 0; b--)
         r = {r[14:0], 1'b0} ^ ((r[15] ^ d[b]) ? crc_poly : 16'h0000);
      return r;
   endfunction

   task automatic wr(input logic [15:0] d, input logic rdy);
      dw_wdata = d;
      dw_wvalid = 1'b1;
      #1 `CHK(dw_wready, rdy)
      `CHK(tx_dma_request, rdy)
      @(negedge sys_clk);
   endtask

   task automatic pulse(ref logic s);
      s = 1'b1;
      @(negedge sys_clk);
      s = 1'b0;
      @(negedge sys_clk);
   endtask

   task automatic xfer(input int nb, input logic sel);
      rxq = {};
      i_scc_spi_master.frame(tq, nb, sel, mq);
      repeat (8) @(negedge sys_clk);
      `CHK(flags.link_busy, 1'b0)
      `CHK(miso_oe, 1'b0)
   endtask

   task automatic crc_restart();
      peripheral_enable = 1'b0;
      checksum_enable = 1'b0;
      @(negedge sys_clk);
      checksum_enable = 1'b1;
      repeat (2) @(negedge sys_clk);
      `CHK(rx_checksum_register, 16'h0000)
      peripheral_enable = 1'b1;
   endtask

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // drains the receive buffer into the model queue
   always @(negedge sys_clk)
   begin
      dw_rd <= 1'b0;
      if (auto_rd && flags.rx_buffer_not_empty === 1'b1 && !dw_rd)
      begin
         dw_rd <= 1'b1;
         rxq.push_back(dw_rdata);
      end
   end

   initial
   begin
      #200000;
      fail_count++;
      tally_and_finish();
   end

   // ----
   // main sequence
   // ----
   initial
   begin
      {srst, clk_en} = 2'h3;
      {peripheral_enable, checksum_enable, word16, i2s_mode, set_send_next, dw_wvalid, auto_rd} = 7'h00;
      {clr_mismatch, clr_overrun, mode_fault_in, underrun_in, frame_err_in, clr_audio_err} = 6'h00;
      {tx_irq_enable, rx_irq_enable, error_irq_enable, tx_dma_enable, rx_dma_enable, channel_side_in} = 6'h3f;
      crc_poly = rnd() | 16'h0001;
      dw_wdata = 16'h0000;
      repeat (12) @(negedge sys_clk);
      srst = 1'b0;
      @(negedge sys_clk);
      `CHK(flags, 9'h101)
      // fill until refused, then the link drains it
      {peripheral_enable, word16, auto_rd} = 3'h7;
      tq = {rnd(), rnd()};
      wr(tq[0], 1'b1);
      wr(tq[1], 1'b1);
      wr(rnd(), 1'b0);
      dw_wvalid = 1'b0;
      mq = tq;
      tq = {rnd(), rnd()};
      d0 = mq[0];
      xfer(16, 1'b1);
      `CHK(mq[0], d0)
      `CHK(rxq[1], tq[1])
      // short words sit in the low bits
      word16 = 1'b0;
      d0 = rnd();
      wr(d0, 1'b1);
      dw_wvalid = 1'b0;
      tq = {rnd()};
      xfer(8, 1'b1);
      `CHK(mq[0][7:0], d0[7:0])
      `CHK(rxq[0][7:0], tq[0][7:0])
      // unread buffer: second word dropped
      {word16, auto_rd} = 2'h2;
      tq = {rnd()};
      d0 = tq[0];
      xfer(16, 1'b1);
      tq = {rnd()};
      xfer(16, 1'b1);
      `CHK(flags.overrun_error, 1'b1)
      `CHK(dw_rdata, d0)
      `CHK(rx_dma_request, 1'b1)
      auto_rd = 1'b1;
      pulse(clr_overrun);
      `CHK(err_irq, 1'b0)
      // checksum appended, good then corrupted
      for (int k = 0; k < 2; k++)
      begin
         crc_restart();
         d0 = rnd();
         pulse(set_send_next);
         wr(d0, 1'b1);
         dw_wvalid = 1'b0;
         tq = {rnd(), 16'h0000};
         tq[1] = crc_of(tq[0]) ^ {16{k[0]}};
         xfer(16, 1'b1);
         `CHK(mq[1], crc_of(d0))
         `CHK(tx_checksum_value, crc_of(d0))
         `CHK(rxq[0], tq[0])
         `CHK(flags.checksum_mismatch, k[0])
      end
      i2s_mode = 1'b1;
      repeat (2) @(negedge sys_clk);
      `CHK(flags.checksum_mismatch, 1'b0)
      i2s_mode = 1'b0;
      pulse(clr_mismatch);
      `CHK(flags.checksum_mismatch, 1'b0)
      // checksum runs while disabled and deselected
      crc_restart();
      peripheral_enable = 1'b0;
      tq = {rnd()};
      xfer(16, 1'b0);
      `CHK(rx_checksum_register, crc_of(tq[0]))
      peripheral_enable = 1'b1;
      for (int m = 0; m < 2; m++)
      begin
         i2s_mode = m[0];
         {mode_fault_in, underrun_in, frame_err_in} = 3'h7;
         @(negedge sys_clk);
         {mode_fault_in, underrun_in, frame_err_in} = 3'h0;
         @(negedge sys_clk);
         `CHK({flags.mode_fault, flags.underrun_error, flags.frame_format_error}, {!m[0], m[0], m[0]})
         `CHK(err_irq, 1'b1)
         pulse(clr_audio_err);
         `CHK(err_irq, 1'b0)
      end
      tally_and_finish();
   end
endmodule
